// ### design/crc_bank.sv
// Purpose: Clock synthesizer select, receive mute, loss-of-signal and test control bank.
// Assumes: Host port signals and line inputs are synchronous to clk.
// Notes: Host reads return stored register contents one cycle after the read strobe.
`timescale 1ns/1ps
module crc_bank (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Host register port
  input wire logic [4:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  // Mode and hardware pins
  input wire logic hw_mode,
  input wire logic [2:0] hw_synth_source_sel,
  input wire logic hw_master_rate_select,
  input wire logic board_test_pin_n,
  // Receive line side
  input wire logic rx_bit_strobe,
  input wire logic rx_pos_in,
  input wire logic rx_neg_in,
  input wire logic rx_clk_in,
  // Receive outputs
  output logic rx_positive_data_out,
  output logic rx_negative_violation_out,
  output logic rx_clk_out,
  output logic receive_signal_lost,
  // Synthesizer control
  output logic synth_source_sel_2,
  output logic synth_source_sel_1,
  output logic synth_source_sel_0,
  output logic master_rate_select,
  output logic [11:0] synth_ref_khz,
  output logic [11:0] synth_out_khz,
  // Line and test control
  output logic wire_size_sel_hi,
  output logic wire_size_sel_lo,
  output crc_pkg::crc_gauge_e cable_model,
  output logic transmit_enable_handover,
  output logic termination_select_handover,
  output logic board_test_tristate,
  output logic pins_output_enable
);

  // ==========================================================
  // Register storage
  logic [7:0] clock_synth_and_receive_control;
  logic [7:0] line_gauge_and_path_control;
  // Selects are shared by the write enables and the read mux so both stay in step
  logic sel_synth;
  logic sel_gauge;
  logic [7:0] read_mux;

  // Address decode
  // Only the two addresses of this bank are decoded; all others are ignored
  assign sel_synth = (host_addr == crc_pkg::CRC_ADDR_SYNTH_RX);
  assign sel_gauge = (host_addr == crc_pkg::CRC_ADDR_GAUGE_PATH);
  // Unmapped addresses read as zero; reserved top bit of the synth register reads zero
  assign read_mux = sel_synth ? clock_synth_and_receive_control :
    (sel_gauge ? line_gauge_and_path_control : 8'h00);

  // Host writes
  // The reserved top bit of the synth register is dropped so it always reads zero
  always_ff @(posedge clk) begin
    if (reset) begin
      clock_synth_and_receive_control <= crc_pkg::CRC_SYNTH_RX_RESET;
      line_gauge_and_path_control <= crc_pkg::CRC_GAUGE_PATH_RESET;
    end else if (host_wr) begin
      if (sel_synth) begin
        clock_synth_and_receive_control <= host_wdata & crc_pkg::CRC_SYNTH_RX_MASK;
      end
      if (sel_gauge) begin
        line_gauge_and_path_control <= host_wdata;
      end
    end
  end

  // Host read answer
  // Read data holds until the next read, so a slow host may pick it up late
  // A read and a write in one cycle: the read returns the old contents
  always_ff @(posedge clk) begin
    if (reset) begin
      host_rdata <= 8'h00;
      host_rvalid <= 1'b0;
    end else begin
      host_rdata <= host_rd ? read_mux : host_rdata;
      host_rvalid <= host_rd;
    end
  end

  // ==========================================================
  // Field extraction
  logic [2:0] reg_source;
  logic reg_rate;
  logic mute;
  logic ext_loss;
  logic reg_test;
  logic [1:0] gauge;

  // Top bits of the multi-bit fields, declared ahead of the slices that use them
  localparam int CRC_SRC_MSB = crc_pkg::CRC_SRC_LSB + 2;
  localparam int CRC_GAUGE_MSB = crc_pkg::CRC_GAUGE_LSB + 1;

  // Field slices are named so the selection logic below reads plainly
  assign reg_source = clock_synth_and_receive_control[CRC_SRC_MSB:crc_pkg::CRC_SRC_LSB];
  assign reg_rate = clock_synth_and_receive_control[crc_pkg::CRC_RATE_BIT];
  assign mute = clock_synth_and_receive_control[crc_pkg::CRC_MUTE_BIT];
  assign ext_loss = clock_synth_and_receive_control[crc_pkg::CRC_EXLOSS_BIT];
  assign reg_test = clock_synth_and_receive_control[crc_pkg::CRC_TEST_BIT];
  assign gauge = line_gauge_and_path_control[CRC_GAUGE_MSB:crc_pkg::CRC_GAUGE_LSB];

  // ==========================================================
  // Synthesizer selection
  logic [2:0] next_source;
  logic next_rate;
  logic [11:0] next_ref_khz;
  logic [11:0] next_out_khz;

  // Register source and rate bits lose all effect in hardware mode, so pins cannot fight software
  // Source and rate pass one register stage together, so the synthesizer sees one change
  assign next_source = hw_mode ? hw_synth_source_sel : reg_source;
  assign next_rate = hw_mode ? hw_master_rate_select : reg_rate;
  assign next_out_khz = next_rate ? crc_pkg::CRC_KHZ_T1 : crc_pkg::CRC_KHZ_E1;

  // Reference input implied by the source code
  // Every code is listed; the default only guards against unknown selects
  always_comb begin
    case (next_source)
      3'b000: next_ref_khz = crc_pkg::CRC_KHZ_E1;
      3'b001: next_ref_khz = crc_pkg::CRC_KHZ_T1;
      3'b010: next_ref_khz = crc_pkg::CRC_KHZ_8;
      3'b011: next_ref_khz = crc_pkg::CRC_KHZ_16;
      3'b100: next_ref_khz = crc_pkg::CRC_KHZ_56;
      3'b101: next_ref_khz = crc_pkg::CRC_KHZ_64;
      3'b110: next_ref_khz = crc_pkg::CRC_KHZ_128;
      3'b111: next_ref_khz = crc_pkg::CRC_KHZ_256;
      default: next_ref_khz = crc_pkg::CRC_KHZ_E1;
    endcase
  end

  // Synthesizer outputs
  // Reset leaves the synthesizer on the E1 reference and rate, a defined start
  always_ff @(posedge clk) begin
    if (reset) begin
      {synth_source_sel_2, synth_source_sel_1, synth_source_sel_0} <= 3'b000;
      master_rate_select <= 1'b0;
      synth_ref_khz <= crc_pkg::CRC_KHZ_E1;
      synth_out_khz <= crc_pkg::CRC_KHZ_E1;
    end else begin
      {synth_source_sel_2, synth_source_sel_1, synth_source_sel_0} <= next_source;
      master_rate_select <= next_rate;
      synth_ref_khz <= next_ref_khz;
      synth_out_khz <= next_out_khz;
    end
  end

  // ==========================================================
  // Receive path and loss of signal
  // The zero counter watches the raw inputs, so muting never hides a loss
  // Its threshold follows the effective rate, whether from the pin or the register
  crc_los_if los_link ();

  assign los_link.bit_strobe = rx_bit_strobe;
  assign los_link.zero_bit = !(rx_pos_in || rx_neg_in);
  assign los_link.extended = ext_loss;
  assign los_link.t1_mode = next_rate;

  crc_los_counter u_los (
    .clk(clk),
    .reset(reset),
    .los(los_link)
  );

  // Data and clock share one register stage so their alignment is kept
  // Mute gates only the data; the recovered clock is never gated
  // The loss flag gets one more stage here so every output leaves from a flop
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_positive_data_out <= 1'b0;
      rx_negative_violation_out <= 1'b0;
      rx_clk_out <= 1'b0;
      receive_signal_lost <= 1'b0;
    end else begin
      rx_positive_data_out <= rx_pos_in && !mute;
      rx_negative_violation_out <= rx_neg_in && !mute;
      rx_clk_out <= rx_clk_in;
      receive_signal_lost <= los_link.lost;
    end
  end

  // ==========================================================
  // Line, hand-over and test controls
  logic next_tristate;
  // Either source requests the tri-state condition; the pin is active low

  assign next_tristate = reg_test || !board_test_pin_n;

  // Pad enables follow the test request; the pads themselves sit outside this bank
  // Hand-over bits are stored and passed on only; what they switch lies outside
  // The gauge field leaves both as raw bits and as the cable model value
  always_ff @(posedge clk) begin
    if (reset) begin
      {wire_size_sel_hi, wire_size_sel_lo} <= 2'b00;
      cable_model <= crc_pkg::CRC_GAUGE_MIXED;
      transmit_enable_handover <= 1'b0;
      termination_select_handover <= 1'b0;
      board_test_tristate <= 1'b0;
      pins_output_enable <= 1'b0;
    end else begin
      {wire_size_sel_hi, wire_size_sel_lo} <= gauge;
      cable_model <= crc_pkg::crc_gauge_e'(gauge);
      transmit_enable_handover <= line_gauge_and_path_control[crc_pkg::CRC_TXON_BIT];
      termination_select_handover <= line_gauge_and_path_control[crc_pkg::CRC_TERM_BIT];
      board_test_tristate <= next_tristate;
      pins_output_enable <= !next_tristate;
    end
  end

endmodule

// ### design/crc_pkg.sv
// Purpose: Shared constants and types for the clock synthesizer and receive control bank.
// Assumes: One 200 MHz clock and a synchronous active-high reset.
// Notes: Register indices are the printed host-port addresses.
package crc_pkg;

  // ==========================================================
  // Register map
  localparam logic [4:0] CRC_ADDR_SYNTH_RX = 5'h11;
  localparam logic [4:0] CRC_ADDR_GAUGE_PATH = 5'h12;
  localparam logic [7:0] CRC_SYNTH_RX_RESET = 8'h00;
  localparam logic [7:0] CRC_GAUGE_PATH_RESET = 8'h00;
  localparam logic [7:0] CRC_SYNTH_RX_MASK = 8'h7f;

  // ==========================================================
  // Field positions, clock synthesizer and receive control
  localparam int CRC_SRC_LSB = 4;
  localparam int CRC_RATE_BIT = 3;
  localparam int CRC_MUTE_BIT = 2;
  localparam int CRC_EXLOSS_BIT = 1;
  localparam int CRC_TEST_BIT = 0;

  // Field positions, gauge and path control
  localparam int CRC_GAUGE_LSB = 6;
  localparam int CRC_TXON_BIT = 5;
  localparam int CRC_TERM_BIT = 4;

  // ==========================================================
  // Loss-of-signal zero counts
  localparam int CRC_LOS_CNT_W = 13;
  localparam logic [12:0] CRC_LOS_EXT_ZEROS = 13'd4096;
  localparam logic [12:0] CRC_LOS_T1_BASE = 13'd175;
  localparam logic [12:0] CRC_LOS_T1_EXTRA = 13'd75;
  localparam logic [12:0] CRC_LOS_E1_ZEROS = 13'd32;

  // ==========================================================
  // Synthesizer frequencies in kHz
  localparam logic [11:0] CRC_KHZ_E1 = 12'd2048;
  localparam logic [11:0] CRC_KHZ_T1 = 12'd1544;
  localparam logic [11:0] CRC_KHZ_8 = 12'd8;
  localparam logic [11:0] CRC_KHZ_16 = 12'd16;
  localparam logic [11:0] CRC_KHZ_56 = 12'd56;
  localparam logic [11:0] CRC_KHZ_64 = 12'd64;
  localparam logic [11:0] CRC_KHZ_128 = 12'd128;
  localparam logic [11:0] CRC_KHZ_256 = 12'd256;

  // Cable model chosen by the gauge field
  typedef enum logic [1:0] {
    CRC_GAUGE_MIXED = 2'b00,
    CRC_GAUGE_22 = 2'b01,
    CRC_GAUGE_24 = 2'b10,
    CRC_GAUGE_26 = 2'b11
  } crc_gauge_e;

endpackage

// ### design/crc_los_if.sv
// Purpose: Carrier between the control bank and its zero counter.
// Assumes: Both ends on the same clock.
// Notes: The bank drives the strobe and settings; the counter returns the flag.
`timescale 1ns/1ps
interface crc_los_if;
  logic bit_strobe;
  logic zero_bit;
  logic extended;
  logic t1_mode;
  logic lost;
  modport bank (output bit_strobe, output zero_bit, output extended, output t1_mode,
    input lost);
  modport counter (input bit_strobe, input zero_bit, input extended, input t1_mode,
    output lost);
endinterface

// ### design/crc_los_counter.sv
// Purpose: Counts consecutive received zeros and declares loss of signal.
// Assumes: One bit_strobe per received bit period.
// Notes: Any mark bit clears the count and the flag at once.
`timescale 1ns/1ps
module crc_los_counter (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link to the control bank
  crc_los_if.counter los
);

  logic [crc_pkg::CRC_LOS_CNT_W-1:0] zero_count;
  logic [crc_pkg::CRC_LOS_CNT_W-1:0] next_zero_count;
  logic [crc_pkg::CRC_LOS_CNT_W-1:0] threshold;
  logic lost;
  logic next_lost;
  logic at_threshold;

  // ==========================================================
  // Threshold selection
  assign threshold = los.extended ? crc_pkg::CRC_LOS_EXT_ZEROS :
    (los.t1_mode ? crc_pkg::CRC_LOS_T1_BASE + crc_pkg::CRC_LOS_T1_EXTRA
                 : crc_pkg::CRC_LOS_E1_ZEROS);
  // Counter saturates at the threshold so it never wraps into a false clear
  assign at_threshold = (zero_count >= threshold);
  assign next_zero_count = !los.bit_strobe ? zero_count :
    (!los.zero_bit ? '0 : (at_threshold ? zero_count : zero_count + 1'b1));
  assign next_lost = !los.bit_strobe ? lost :
    (!los.zero_bit ? 1'b0 : (zero_count + 1'b1 >= threshold));

  // Count register
  always_ff @(posedge clk) begin
    if (reset) begin
      zero_count <= '0;
      lost <= 1'b0;
    end else begin
      zero_count <= next_zero_count;
      lost <= next_lost;
    end
  end

  assign los.lost = lost;

endmodule

// ### dv/crc_bank_chk.sv
// Purpose: Port assertions for the clock and receive control bank.
// Assumes: One clock, synchronous active-high reset.
// Notes: Register shadows are rebuilt from host writes.
`timescale 1ns/1ps
module crc_bank_chk (
  // Clock, reset and host writes
  input wire logic clk,
  input wire logic reset,
  input wire logic [4:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_wr,
  // Pins and line inputs
  input wire logic hw_mode,
  input wire logic [2:0] hw_synth_source_sel,
  input wire logic hw_master_rate_select,
  input wire logic board_test_pin_n,
  input wire logic rx_bit_strobe,
  input wire logic rx_pos_in,
  input wire logic rx_neg_in,
  input wire logic rx_clk_in,
  // Observed outputs
  input wire logic rx_positive_data_out,
  input wire logic rx_negative_violation_out,
  input wire logic rx_clk_out,
  input wire logic receive_signal_lost,
  input wire logic synth_source_sel_2,
  input wire logic synth_source_sel_1,
  input wire logic synth_source_sel_0,
  input wire logic master_rate_select,
  input wire logic [11:0] synth_ref_khz,
  input wire logic [11:0] synth_out_khz,
  input wire logic wire_size_sel_hi,
  input wire logic wire_size_sel_lo,
  input wire logic board_test_tristate,
  input wire logic pins_output_enable
);
  localparam logic [11:0] REF_KHZ [8] = '{12'h800, 12'h608, 12'h008, 12'h010,
    12'h038, 12'h040, 12'h080, 12'h100};
  logic [7:0] r17;
  logic [7:0] r18;
  logic [12:0] zc;
  // ==========================================
  // Shadow state
  // Threshold follows the effective rate, so pin mode changes it too
  wire [12:0] thr = r17[1] ? 13'h1000 : (master_rate_select ? 13'h00fa : 13'h0020);
  wire [2:0] src = {synth_source_sel_2, synth_source_sel_1, synth_source_sel_0};
  wire [2:0] eff_src = hw_mode ? hw_synth_source_sel : r17[6:4];
  wire eff_rate = hw_mode ? hw_master_rate_select : r17[3];
  wire test_req = r17[0] | ~board_test_pin_n;
  wire mute = r17[2];
  wire [1:0] gauge = r18[7:6];
  wire mark = rx_pos_in | rx_neg_in;
  // Zero run saturates so a long idle line cannot wrap back under threshold
  always_ff @(posedge clk) begin
    if (reset) begin
      r17 <= 8'h00;
      r18 <= 8'h00;
      zc <= 13'h0000;
    end else begin
      if (host_wr && host_addr == 5'h11) r17 <= host_wdata;
      if (host_wr && host_addr == 5'h12) r18 <= host_wdata;
      if (rx_bit_strobe) zc <= mark ? 13'h0000 : (&zc ? zc : zc + 13'h0001);
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_live; !$past(reset); endsequence
  sequence s_mark; rx_bit_strobe && mark; endsequence
  a_source_follows: assert property (s_live |-> src == $past(eff_src))
    else $error("source select wrong");
  a_rate_follows: assert property (s_live |-> master_rate_select == $past(eff_rate))
    else $error("rate select wrong");
  a_freq_table: assert property (synth_ref_khz == REF_KHZ[src] &&
    synth_out_khz == (master_rate_select ? 12'h608 : 12'h800)) else $error("freq wrong");
  a_mute_low: assert property (s_live ##0 $past(mute) |->
    !rx_positive_data_out && !rx_negative_violation_out) else $error("mute leaks");
  a_data_pass: assert property (s_live ##0 !$past(mute) |->
    rx_positive_data_out == $past(rx_pos_in) && rx_negative_violation_out == $past(rx_neg_in))
    else $error("data path wrong");
  a_clock_runs: assert property (s_live |-> rx_clk_out == $past(rx_clk_in))
    else $error("receive clock wrong");
  a_test_tristate: assert property (s_live |-> board_test_tristate == $past(test_req) &&
    pins_output_enable == !board_test_tristate) else $error("tristate wrong");
  a_gauge_field: assert property (s_live |->
    {wire_size_sel_hi, wire_size_sel_lo} == $past(gauge)) else $error("gauge wrong");
  // Flag shows one edge after the deciding strobe, when the run already equals the threshold
  a_loss_count: assert property ($rose(receive_signal_lost) |-> zc == thr)
    else $error("loss at wrong count");
  a_loss_clear: assert property (s_mark |-> ##2 !receive_signal_lost)
    else $error("loss not cleared");
endmodule

bind crc_bank crc_bank_chk chk (.*);

// ### dv/tb.sv
// Purpose: Self-checking bench for the clock and receive control bank.
// Assumes: Inputs change on the falling edge; outputs are registered.
// Notes: Integer model tracks both registers from host traffic.
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] host_addr = 5'h00;
  logic [7:0] host_wdata = 8'h00;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic hw_mode = 1'b0;
  logic [2:0] hw_synth_source_sel = 3'h0;
  logic hw_master_rate_select = 1'b0;
  logic board_test_pin_n = 1'b1;
  logic rx_bit_strobe = 1'b0;
  logic rx_pos_in = 1'b0;
  logic rx_neg_in = 1'b0;
  logic rx_clk_in = 1'b0;
  logic [7:0] host_rdata;
  logic host_rvalid, rx_positive_data_out, rx_negative_violation_out, rx_clk_out;
  logic receive_signal_lost, synth_source_sel_2, synth_source_sel_1, synth_source_sel_0;
  logic master_rate_select, wire_size_sel_hi, wire_size_sel_lo, transmit_enable_handover;
  logic termination_select_handover, board_test_tristate, pins_output_enable;
  logic [11:0] synth_ref_khz, synth_out_khz;
  crc_pkg::crc_gauge_e cable_model;
  int m17 = 0;
  int m18 = 0;
  int err_count = 0;
  int compares = 0;
  int ref_tab [8] = '{2048, 1544, 8, 16, 56, 64, 128, 256};
  crc_bank dut (.*);
  // ==========================================
  // Helpers
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  // Extra falling edge lets the one-cycle output update land
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    host_wr = 1'b1;
    host_addr = a;
    host_wdata = d;
    @(negedge clk);
    host_wr = 1'b0;
    if (a == 5'h11) m17 = d & 8'h7f;
    if (a == 5'h12) m18 = d;
    @(negedge clk);
  endtask
  task automatic rd(input logic [4:0] a, input int exp);
    @(negedge clk);
    host_rd = 1'b1;
    host_addr = a;
    @(negedge clk);
    check("read valid", host_rvalid, 1);
    check("read data", host_rdata, exp);
    host_rd = 1'b0;
    @(negedge clk);
    check("read valid low", host_rvalid, 0);
  endtask
  task automatic send(input int n, input logic p);
    rx_pos_in = p;
    rx_neg_in = 1'b0;
    rx_bit_strobe = 1'b1;
    repeat (n) @(negedge clk);
    rx_bit_strobe = 1'b0;
    @(negedge clk);
  endtask
  task automatic check_outs();
    int src;
    int rate;
    int t;
    src = hw_mode ? hw_synth_source_sel : (m17 >> 4) & 7;
    rate = hw_mode ? hw_master_rate_select : (m17 >> 3) & 1;
    t = (m17 & 1) | !board_test_pin_n;
    check("source", {synth_source_sel_2, synth_source_sel_1, synth_source_sel_0}, src);
    check("rate", master_rate_select, rate);
    check("ref khz", synth_ref_khz, ref_tab[src]);
    check("out khz", synth_out_khz, rate ? 1544 : 2048);
    check("cable", cable_model, m18 >> 6);
    check("wire size", {wire_size_sel_hi, wire_size_sel_lo}, m18 >> 6);
    check("handover", {transmit_enable_handover, termination_select_handover}, (m18 >> 4) & 3);
    check("tristate", board_test_tristate, t);
    check("enable", pins_output_enable, !t);
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================
  // Clock, watchdog and tests
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Tests need about 4600 cycles; allow over four times that
  initial begin
    #100000;
    err_count++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h98589d5e));
    repeat (12) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    check_outs();
    rd(5'h11, 0);
    rd(5'h12, 0);
    repeat (4) begin
      wr(5'h11, 8'($urandom));
      wr(5'h12, 8'($urandom));
      rd(5'h11, m17);
      rd(5'h12, m18);
    end
    wr(5'h05, 8'hff);
    rd(5'h05, 0);
    check_outs();
    for (int i = 0; i < 16; i++) begin
      wr(5'h11, 8'(i << 3));
      check_outs();
    end
    for (int i = 0; i < 4; i++) begin
      wr(5'h12, 8'((i << 6) | ($urandom & 8'h3f)));
      check_outs();
      board_test_pin_n = i[0];
      wr(5'h11, 8'(i >> 1));
      check_outs();
    end
    board_test_pin_n = 1'b1;
    hw_mode = 1'b1;
    repeat (6) begin
      hw_synth_source_sel = 3'($urandom);
      hw_master_rate_select = 1'($urandom);
      wr(5'h11, 8'($urandom & 8'h7e));
      check_outs();
    end
    hw_mode = 1'b0;
    for (int m = 0; m < 2; m++) begin
      wr(5'h11, 8'(m << 2));
      repeat (8) begin
        rx_pos_in = 1'($urandom);
        rx_neg_in = 1'($urandom);
        rx_clk_in = 1'($urandom);
        @(negedge clk);
        check("rx pos", rx_positive_data_out, m ? 0 : rx_pos_in);
        check("rx neg", rx_negative_violation_out, m ? 0 : rx_neg_in);
        check("rx clk", rx_clk_out, rx_clk_in);
      end
    end
    for (int i = 0; i < 3; i++) begin
      wr(5'h11, i == 0 ? 8'h00 : (i == 1 ? 8'h08 : 8'h02));
      send(i == 0 ? 31 : (i == 1 ? 249 : 4095), 1'b0);
      check("loss early", receive_signal_lost, 0);
      send(1, 1'b0);
      check("loss set", receive_signal_lost, 1);
      send(1, 1'b1);
      check("loss clear", receive_signal_lost, 0);
    end
    finish_test();
  end
endmodule
